/* src/rsw_pkg.sv */
// package: constants for the rtc supervisor, watchdog and interrupt block
package rsw_pkg;
    // ------------------------------------------------------------
    // clocks
    // ------------------------------------------------------------
    localparam int CORE_CLK_HZ = 20_000_000;
    localparam int OSC_HZ      = 32_768;
    localparam int CNT_W       = 17;

    // ------------------------------------------------------------
    // times and derived counts
    // ------------------------------------------------------------
    localparam int PB_MIN_NS        = 1000;
    localparam int PB_MIN_CYC       = (PB_MIN_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ADDR_STABLE_NS   = 50;
    localparam int ADDR_STABLE_CYC  = (ADDR_STABLE_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CYCLE_FINISH_US  = 10;
    localparam int CYCLE_FINISH_CYC = CYCLE_FINISH_US * (CORE_CLK_HZ / 1_000_000);
    localparam int POR_HOLD_MS      = 200;
    localparam int POR_HOLD_TICKS   = (POR_HOLD_MS * OSC_HZ + 999) / 1000;
    localparam int ENABLE_HOLD_MS   = 200;
    localparam int ENABLE_HOLD_TICKS = (ENABLE_HOLD_MS * OSC_HZ) / 1000;
    localparam int PROTECT_EXT_MS   = 200;
    localparam int PROTECT_EXT_TICKS = (PROTECT_EXT_MS * OSC_HZ + 999) / 1000;
    localparam int PB_HOLD_MS       = 200;
    localparam int PB_HOLD_TICKS    = (PB_HOLD_MS * OSC_HZ + 999) / 1000;

    // ------------------------------------------------------------
    // watchdog and reset time-out tables, in oscillator ticks
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] WDOG_TICKS_TBL [0:7] = '{
        17'h0C000, 17'h00300, 17'h00600, 17'h00C00,
        17'h01800, 17'h03000, 17'h06000, 17'h18000};
    localparam logic [CNT_W-1:0] WRST_TICKS_TBL [0:7] = '{
        17'h00008, 17'h00080, 17'h00100, 17'h00200,
        17'h00400, 17'h00800, 17'h01000, 17'h04000};
    localparam logic [2:0] WDOG_SEL_RESET = 3'h0;

    // ------------------------------------------------------------
    // interrupts, register port and watchdog states
    // ------------------------------------------------------------
    localparam int IRQ_PERIODIC = 0;
    localparam int IRQ_ALARM    = 1;
    localparam int IRQ_PWRFAIL  = 2;
    localparam logic [3:0] FLAG_ADDR = 4'hD;
    localparam int PRESC_W = 15;

    typedef enum logic [1:0] {
        WD_OFF = 2'h0,
        WD_RUN = 2'h1,
        WD_RST = 2'h3
    } rsw_wd_state_type;
endpackage : rsw_pkg

/* src/rsw_sync.sv */
// two-flop synchroniser, one generate lane per bit
`timescale 1ns/1ns
`default_nettype none
module rsw_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         sys_rst_in,
    // data
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    for (genvar i = 0; i < W; i++) begin : g_lane
        logic meta_reg;
        always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
                meta_reg <= 1'b0;
                q_out[i] <= 1'b0;
            end else begin
                meta_reg <= d_in[i];
                q_out[i] <= meta_reg;
            end
        end
    end
endmodule : rsw_sync
`default_nettype wire

/* src/rsw_hold_timer.sv */
// loadable down-counter of oscillator ticks with busy flag
`timescale 1ns/1ns
`default_nettype none
module rsw_hold_timer
    import rsw_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    // control
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] value_in,
    input  wire logic             tick_in,
    // status
    output var  logic             busy_out
);
    logic [CNT_W-1:0] cnt_reg;
    wire              cnt_zero = (cnt_reg == '0);

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cnt_reg <= '0;
        end else if (load_in) begin
            cnt_reg <= value_in;
        end else if (tick_in && !cnt_zero) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign busy_out = !cnt_zero;
endmodule : rsw_hold_timer
`default_nettype wire

/* src/rsw_supervisor.sv */
// top: cpu supervisor, sram enable gating, watchdog and interrupt combiner
`timescale 1ns/1ns
`default_nettype none
module rsw_supervisor
    import rsw_pkg::*;
#(
    parameter logic [CNT_W-1:0] POR_HOLD     = CNT_W'(POR_HOLD_TICKS),
    parameter logic [CNT_W-1:0] ENABLE_HOLD  = CNT_W'(ENABLE_HOLD_TICKS),
    parameter logic [CNT_W-1:0] PROTECT_EXT  = CNT_W'(PROTECT_EXT_TICKS),
    parameter logic [CNT_W-1:0] PB_HOLD      = CNT_W'(PB_HOLD_TICKS)
) (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    // oscillator and power detectors
    input  wire logic       osc_clk_in,
    input  wire logic       power_fail_in,
    input  wire logic       backup_mode_in,
    input  wire logic       battery_valid_in,
    input  wire logic       osc_run_in_backup_in,
    output var  logic       osc_enable_out,
    output var  logic       backup_isolate_out,
    // host register port
    input  wire logic [3:0] host_addr_in,
    input  wire logic       host_rd_in,
    input  wire logic       host_wr_in,
    input  wire logic [2:0] wdog_period_sel_in,
    input  wire logic       wdog_sel_wr_in,
    output var  logic       host_wr_allow_out,
    output var  logic [2:0] wdog_period_sel_out,
    // external sram enable
    input  wire logic       chip_enable_n_in,
    output var  logic       gated_chip_enable_n_out,
    // reset pin, open drain
    input  wire logic       sup_reset_n_in,
    output var  logic       sup_reset_n_out,
    output var  logic       sup_reset_oe_out,
    // watchdog
    input  wire logic       wdog_kick_in,
    input  wire logic       wdog_float_in,
    output var  logic       wdog_expired_out,
    // interrupts
    input  wire logic       alarm_match_in,
    input  wire logic [3:0] periodic_rate_in,
    input  wire logic [2:0] irq_enable_in,
    output var  logic [2:0] irq_flags_out,
    output var  logic       irq_n_out,
    output var  logic       irq_oe_out
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SW = 12;
    logic [SW-1:0] raw_pins;
    logic [SW-1:0] sy;
    assign raw_pins = {osc_clk_in, power_fail_in, backup_mode_in, battery_valid_in,
                       host_rd_in, host_wr_in, chip_enable_n_in, sup_reset_n_in,
                       wdog_kick_in, wdog_float_in, alarm_match_in, wdog_sel_wr_in};

    rsw_sync #(.W(SW)) u_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .d_in        (raw_pins),
        .q_out       (sy)
    );

    wire osc_s   = sy[11];
    wire pf_s    = sy[10];
    wire bkup_s  = sy[9];
    wire batt_s  = sy[8];
    wire rd_s    = sy[7];
    wire wr_s    = sy[6];
    wire ce_n_s  = sy[5];
    wire rst_n_s = sy[4];
    wire kick_s  = sy[3];
    wire float_s = sy[2];
    wire alarm_s = sy[1];
    wire wsel_s  = sy[0];

    logic [3:0] addr_s1_reg;
    logic [3:0] addr_s2_reg;

    // ------------------------------------------------------------
    // edge detectors and oscillator tick
    // ------------------------------------------------------------
    logic osc_prev_reg;
    logic pf_prev_reg;
    logic kick_prev_reg;
    logic alarm_prev_reg;
    logic wsel_prev_reg;

    wire osc_tick   = osc_s && !osc_prev_reg;
    wire pf_rise    = pf_s && !pf_prev_reg;
    wire pf_fall    = !pf_s && pf_prev_reg;
    wire kick_edge  = kick_s != kick_prev_reg;
    wire alarm_rise = alarm_s && !alarm_prev_reg;
    wire wsel_rise  = wsel_s && !wsel_prev_reg;

    // ------------------------------------------------------------
    // hold timers
    // ------------------------------------------------------------
    logic por_busy;
    logic ce_hold_busy;
    logic prot_busy;
    logic pb_start;

    rsw_hold_timer u_por (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .load_in     (pf_fall || pb_start),
        .value_in    (pb_start ? PB_HOLD : POR_HOLD),
        .tick_in     (osc_tick),
        .busy_out    (por_busy)
    );

    rsw_hold_timer u_ce_hold (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .load_in     (pf_fall),
        .value_in    (ENABLE_HOLD),
        .tick_in     (osc_tick),
        .busy_out    (ce_hold_busy)
    );

    rsw_hold_timer u_protect (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .load_in     (pf_fall),
        .value_in    (PROTECT_EXT),
        .tick_in     (osc_tick),
        .busy_out    (prot_busy)
    );

    // ------------------------------------------------------------
    // write protection and period select
    // ------------------------------------------------------------
    wire        protect  = pf_s || prot_busy || pf_fall;
    logic [2:0] wsel_reg;
    wire        wsel_load = wsel_rise && !protect;
    wire        wsel_lost = pf_s && !batt_s;

    // ------------------------------------------------------------
    // sram enable gating
    // ------------------------------------------------------------
    logic        ce_block_reg;
    logic [15:0] finish_cnt_reg;
    wire         finish_over = finish_cnt_reg >= 16'(CYCLE_FINISH_CYC);
    wire         ce_idle     = ce_n_s;
    wire         ce_block_next = pf_s ? (ce_block_reg || ce_idle || finish_over)
                                      : (ce_hold_busy || pf_fall);

    // ------------------------------------------------------------
    // push-button reset
    // ------------------------------------------------------------
    logic [7:0] pb_cnt_reg;
    logic       pb_armed_reg;
    logic       rst_drive_reg;
    wire        in_reset_cycle = rst_drive_reg;
    wire        pb_low   = !rst_n_s && !in_reset_cycle;
    assign pb_start = pb_armed_reg && rst_n_s;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    rsw_wd_state_type wd_state_reg;
    rsw_wd_state_type wd_state_next;
    logic [CNT_W-1:0] wd_cnt_reg;
    logic             wdo_reg;
    wire              wd_disable = pf_s || bkup_s || float_s;
    wire [CNT_W-1:0]  wd_period  = WDOG_TICKS_TBL[wsel_reg];
    wire [CNT_W-1:0]  wd_rst_len = WRST_TICKS_TBL[wsel_reg];
    wire              wd_expire  = (wd_state_reg == WD_RUN) && osc_tick
                                   && (wd_cnt_reg >= wd_period - 1'b1);
    wire              wd_rst_end = (wd_state_reg == WD_RST) && osc_tick
                                   && (wd_cnt_reg >= wd_rst_len - 1'b1);

    always_comb begin
        wd_state_next = wd_state_reg;
        case (wd_state_reg)
            WD_OFF: begin
                if (!wd_disable) begin
                    wd_state_next = WD_RUN;
                end
            end
            WD_RUN: begin
                if (wd_disable) begin
                    wd_state_next = WD_OFF;
                end else if (wd_expire && !kick_edge) begin
                    wd_state_next = WD_RST;
                end
            end
            WD_RST: begin
                if (wd_disable) begin
                    wd_state_next = WD_OFF;
                end else if (wd_rst_end) begin
                    wd_state_next = WD_RUN;
                end
            end
            default: wd_state_next = WD_OFF;
        endcase
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] presc_reg;
    logic [2:0]         flags_reg;
    logic [7:0]         addr_age_reg;
    wire [PRESC_W-1:0]  per_mask  = (PRESC_W'(1) << (periodic_rate_in - 4'h1)) - PRESC_W'(1);
    wire                per_event = osc_tick && (periodic_rate_in != 4'h0)
                                    && ((presc_reg & per_mask) == '0);
    wire [2:0]          flag_set;
    assign flag_set[IRQ_PERIODIC] = per_event;
    assign flag_set[IRQ_ALARM]    = alarm_rise;
    assign flag_set[IRQ_PWRFAIL]  = pf_rise;
    wire addr_stable = (addr_s2_reg == FLAG_ADDR) && (addr_s1_reg == addr_s2_reg)
                       && (addr_age_reg >= 8'(ADDR_STABLE_CYC));
    wire flag_clear  = rd_s && addr_stable;
    wire irq_active  = |(flags_reg & irq_enable_in) && !bkup_s;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            osc_prev_reg   <= 1'b0;
            pf_prev_reg    <= 1'b0;
            kick_prev_reg  <= 1'b0;
            alarm_prev_reg <= 1'b0;
            wsel_prev_reg  <= 1'b0;
            addr_s1_reg    <= 4'h0;
            addr_s2_reg    <= 4'h0;
            addr_age_reg   <= 8'h00;
        end else begin
            osc_prev_reg   <= osc_s;
            pf_prev_reg    <= pf_s;
            kick_prev_reg  <= kick_s;
            alarm_prev_reg <= alarm_s;
            wsel_prev_reg  <= wsel_s;
            addr_s1_reg    <= host_addr_in;
            addr_s2_reg    <= addr_s1_reg;
            if (addr_s1_reg != addr_s2_reg) begin
                addr_age_reg <= 8'h00;
            end else if (addr_age_reg != 8'hFF) begin
                addr_age_reg <= addr_age_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wsel_reg           <= WDOG_SEL_RESET;
            backup_isolate_out <= 1'b1;
            osc_enable_out     <= 1'b1;
            host_wr_allow_out  <= 1'b0;
        end else begin
            if (wsel_lost) begin
                wsel_reg <= WDOG_SEL_RESET;
            end else if (wsel_load) begin
                wsel_reg <= wdog_period_sel_in;
            end
            if (!pf_s) begin
                backup_isolate_out <= 1'b0;
            end
            osc_enable_out    <= !bkup_s || osc_run_in_backup_in;
            host_wr_allow_out <= wr_s && !protect;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ce_block_reg   <= 1'b1;
            finish_cnt_reg <= 16'h0000;
        end else begin
            ce_block_reg <= ce_block_next;
            if (pf_s && !finish_over) begin
                finish_cnt_reg <= finish_cnt_reg + 16'h0001;
            end else if (!pf_s) begin
                finish_cnt_reg <= 16'h0000;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pb_cnt_reg    <= 8'h00;
            pb_armed_reg  <= 1'b0;
            rst_drive_reg <= 1'b1;
        end else begin
            if (pb_start) begin
                pb_armed_reg <= 1'b0;
            end else if (pb_low && pb_cnt_reg >= 8'(PB_MIN_CYC - 1)) begin
                pb_armed_reg <= 1'b1;
            end
            pb_cnt_reg    <= pb_low ? pb_cnt_reg + 8'h01 : 8'h00;
            rst_drive_reg <= pf_s || por_busy || pf_fall || pb_start
                             || (wd_state_next == WD_RST);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wd_state_reg <= WD_OFF;
            wd_cnt_reg   <= '0;
            wdo_reg      <= 1'b1;
        end else begin
            wd_state_reg <= wd_state_next;
            if (wd_disable || (kick_edge && wd_state_reg == WD_RUN) || wd_expire || wd_rst_end) begin
                wd_cnt_reg <= '0;
            end else if (osc_tick) begin
                wd_cnt_reg <= wd_cnt_reg + 1'b1;
            end
            if (wd_disable || kick_edge) begin
                wdo_reg <= 1'b1;
            end else if (wd_expire) begin
                wdo_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            presc_reg  <= '0;
            flags_reg  <= 3'h0;
            irq_oe_out <= 1'b0;
        end else begin
            if (osc_tick) begin
                presc_reg <= presc_reg + 1'b1;
            end
            flags_reg  <= (flag_clear ? 3'h0 : flags_reg) | flag_set;
            irq_oe_out <= irq_active && !flag_clear;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign gated_chip_enable_n_out = chip_enable_n_in || ce_block_reg;
    assign sup_reset_n_out         = 1'b0;
    assign sup_reset_oe_out        = rst_drive_reg;
    assign wdog_expired_out        = wdo_reg;
    assign wdog_period_sel_out     = wsel_reg;
    assign irq_flags_out           = flags_reg;
    assign irq_n_out               = 1'b0;
endmodule : rsw_supervisor
`default_nettype wire

/* tb/rsw_supervisor_chk.sv */
// checker: port relations of the supervisor
`timescale 1ns/1ns
`default_nettype none
module rsw_supervisor_chk
    import rsw_pkg::*;
(
    // watched ports
    input wire logic       core_clk_in,
    input wire logic       sys_rst_in,
    input wire logic       power_fail_in,
    input wire logic       backup_mode_in,
    input wire logic       osc_run_in_backup_in,
    input wire logic       osc_enable_out,
    input wire logic [3:0] host_addr_in,
    input wire logic       host_rd_in,
    input wire logic       host_wr_allow_out,
    input wire logic       chip_enable_n_in,
    input wire logic       gated_chip_enable_n_out,
    input wire logic       sup_reset_oe_out,
    input wire logic       wdog_float_in,
    input wire logic       wdog_expired_out,
    input wire logic       alarm_match_in,
    input wire logic [3:0] periodic_rate_in,
    input wire logic [2:0] irq_enable_in,
    input wire logic [2:0] irq_flags_out,
    input wire logic       irq_oe_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_wd_fire;
        $fell(wdog_expired_out);
    endsequence
    sequence s_rst_pull;
        ##[0:2] sup_reset_oe_out;
    endsequence
    sequence s_ce_idle_pf;
        (power_fail_in && chip_enable_n_in) [*4] ##1 power_fail_in;
    endsequence
    a_gate_forced: assert property (s_ce_idle_pf |-> gated_chip_enable_n_out)
        else $error("sram enable not forced off");
    a_gate_pass: assert property ((!power_fail_in && !sup_reset_oe_out) [*4]
        |-> gated_chip_enable_n_out == chip_enable_n_in)
        else $error("sram enable not passed through");
    a_write_block: assert property (power_fail_in [*4] |-> !host_wr_allow_out)
        else $error("write allowed in power fail");
    a_osc_main: assert property (!backup_mode_in [*4] |-> osc_enable_out)
        else $error("oscillator stopped on main supply");
    a_osc_stop: assert property ((backup_mode_in && !osc_run_in_backup_in) [*4] |-> !osc_enable_out)
        else $error("oscillator runs with run bit clear");
    a_wdo_off: assert property ((power_fail_in || backup_mode_in || wdog_float_in) [*4] |-> wdog_expired_out)
        else $error("expiry output low while watchdog off");
    a_wd_reset: assert property (s_wd_fire |-> s_rst_pull)
        else $error("expiry without reset drive");
    a_irq_gate: assert property (irq_oe_out |-> |($past(irq_enable_in) & (irq_flags_out | $past(irq_flags_out))))
        else $error("irq without enabled flag");
    a_flag_clear: assert property ((host_rd_in && host_addr_in == FLAG_ADDR && !alarm_match_in && !power_fail_in
        && periodic_rate_in == 4'h0) [*8] |-> irq_flags_out == 3'h0)
        else $error("flags not cleared by read");
endmodule : rsw_supervisor_chk
bind rsw_supervisor rsw_supervisor_chk u_chk (.core_clk_in, .sys_rst_in, .power_fail_in, .backup_mode_in,
    .osc_run_in_backup_in, .osc_enable_out, .host_addr_in, .host_rd_in, .host_wr_allow_out, .chip_enable_n_in,
    .gated_chip_enable_n_out, .sup_reset_oe_out, .wdog_float_in, .wdog_expired_out, .alarm_match_in,
    .periodic_rate_in, .irq_enable_in, .irq_flags_out, .irq_oe_out);
`default_nettype wire

/* tb/rsw_host_model.sv */
// partner: host kicker and open-drain reset pin
`timescale 1ns/1ns
`default_nettype none
module rsw_host_model (
    // clock and bench control
    input  wire logic core_clk_in,
    input  wire logic kick_en_in,
    input  wire logic press_in,
    // pins
    input  wire logic rst_oe_in,
    output var  logic rst_pin_out,
    output var  logic kick_out
);
    logic [5:0] cnt_reg  = 6'h00;
    logic       kick_reg = 1'b0;
    assign rst_pin_out = !(rst_oe_in || press_in);
    assign kick_out    = kick_reg;
    always_ff @(posedge core_clk_in) begin
        cnt_reg <= cnt_reg + 6'h01;
        if (kick_en_in && cnt_reg == 6'h3F) begin
            kick_reg <= !kick_reg;
        end
    end
endmodule : rsw_host_model
`default_nettype wire

/* tb/tb.sv */
// testbench: supervisor against a bench model
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rsw_pkg::*;
    logic core_clk_in = 1'b0, osc_clk_in = 1'b0, sys_rst_in = 1'b1, power_fail_in = 1'b0, backup_mode_in = 1'b0;
    logic battery_valid_in = 1'b1, osc_run_in_backup_in = 1'b0, osc_enable_out, backup_isolate_out;
    logic [3:0] host_addr_in = 4'h0, periodic_rate_in = 4'h0;
    logic host_rd_in = 1'b0, host_wr_in = 1'b0, wdog_sel_wr_in = 1'b0, host_wr_allow_out;
    logic [2:0] wdog_period_sel_in = 3'h0, wdog_period_sel_out, irq_enable_in = 3'h0, irq_flags_out;
    logic chip_enable_n_in = 1'b1, gated_chip_enable_n_out, sup_reset_n_in, sup_reset_n_out, sup_reset_oe_out;
    logic wdog_kick_in, wdog_float_in = 1'b0, wdog_expired_out, alarm_match_in = 1'b0, irq_n_out, irq_oe_out;
    logic kick_en = 1'b1, press = 1'b0;
    int err_total = 0, checked = 0, n = 0, m_flags = 0;
    int unsigned seed = 77;
    always #25 core_clk_in = ~core_clk_in;
    always #250 osc_clk_in = ~osc_clk_in;
    rsw_supervisor #(.POR_HOLD(17'h00004), .ENABLE_HOLD(17'h00004), .PROTECT_EXT(17'h00004), .PB_HOLD(17'h00004))
    dut (.core_clk_in, .sys_rst_in, .osc_clk_in, .power_fail_in, .backup_mode_in, .battery_valid_in,
        .osc_run_in_backup_in, .osc_enable_out, .backup_isolate_out, .host_addr_in, .host_rd_in, .host_wr_in,
        .wdog_period_sel_in, .wdog_sel_wr_in, .host_wr_allow_out, .wdog_period_sel_out, .chip_enable_n_in,
        .gated_chip_enable_n_out, .sup_reset_n_in, .sup_reset_n_out, .sup_reset_oe_out, .wdog_kick_in,
        .wdog_float_in, .wdog_expired_out, .alarm_match_in, .periodic_rate_in, .irq_enable_in, .irq_flags_out,
        .irq_n_out, .irq_oe_out);
    rsw_host_model u_host (.core_clk_in, .kick_en_in(kick_en), .press_in(press), .rst_oe_in(sup_reset_oe_out),
        .rst_pin_out(sup_reset_n_in), .kick_out(wdog_kick_in));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_in);
        #5;
    endtask : cyc
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(ref logic s, input logic v, input int lim, output int c);
        for (c = 0; c < lim && s !== v; c++) cyc(1);
        chk(s, v);
    endtask : wt
    task automatic conclude();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        #2000000;
        err_total++;
        conclude();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(12);
        chk(backup_isolate_out, 1'b1);
        sys_rst_in = 1'b0;
        cyc(4);
        chk(sup_reset_n_out, 1'b0);
        chk(irq_n_out, 1'b0);
        chk(wdog_period_sel_out, 4'h0);
        chk(irq_flags_out, m_flags[3:0]);
        repeat (8) begin
            n = xs();
            chip_enable_n_in = n[4];
            #1 chk(gated_chip_enable_n_out, chip_enable_n_in);
            cyc(1);
        end
        host_wr_in = 1'b1;
        backup_mode_in = 1'b1;
        cyc(5);
        chk(host_wr_allow_out, 1'b1);
        chk(osc_enable_out, 1'b0);
        osc_run_in_backup_in = 1'b1;
        cyc(5);
        chk(osc_enable_out, 1'b1);
        backup_mode_in = 1'b0;
        alarm_match_in = 1'b1;
        periodic_rate_in = 4'h1;
        cyc(40);
        m_flags = 3;
        chk(irq_flags_out, m_flags[3:0]);
        chk(irq_oe_out, 1'b0);
        irq_enable_in = 3'h2;
        alarm_match_in = 1'b0;
        periodic_rate_in = 4'h0;
        host_rd_in = 1'b1;
        repeat (6) begin
            host_addr_in = (host_addr_in == FLAG_ADDR) ? (FLAG_ADDR ^ 4'h1) : FLAG_ADDR;
            cyc(1);
        end
        chk(irq_oe_out, 1'b1);
        chk(irq_flags_out, m_flags[3:0]);
        host_addr_in = FLAG_ADDR;
        cyc(8);
        m_flags = 0;
        chk(irq_flags_out, m_flags[3:0]);
        chk(irq_oe_out, 1'b0);
        host_rd_in = 1'b0;
        wdog_period_sel_in = 3'h1;
        wdog_sel_wr_in = 1'b1;
        cyc(4);
        wdog_sel_wr_in = 1'b0;
        irq_enable_in = 3'h4;
        chip_enable_n_in = 1'b0;
        power_fail_in = 1'b1;
        cyc(6);
        m_flags = 4;
        chk(irq_flags_out, m_flags[3:0]);
        chk(gated_chip_enable_n_out, 1'b0);
        chk(host_wr_allow_out, 1'b0);
        chk(irq_oe_out, 1'b1);
        wdog_period_sel_in = 3'h5;
        cyc(210);
        chk(gated_chip_enable_n_out, 1'b1);
        chk(sup_reset_oe_out, 1'b1);
        chip_enable_n_in = 1'b1;
        wdog_sel_wr_in = 1'b1;
        cyc(5);
        chip_enable_n_in = 1'b0;
        cyc(3);
        chk(gated_chip_enable_n_out, 1'b1);
        chk(wdog_period_sel_out, 4'h1);
        power_fail_in = 1'b0;
        cyc(6);
        chk(gated_chip_enable_n_out, 1'b1);
        chk(wdog_period_sel_out, 4'h1);
        wt(gated_chip_enable_n_out, 1'b0, 100, n);
        wt(sup_reset_oe_out, 1'b0, 100, n);
        wt(host_wr_allow_out, 1'b1, 100, n);
        chk(backup_isolate_out, 1'b0);
        press = 1'b1;
        cyc(30);
        press = 1'b0;
        wt(sup_reset_oe_out, 1'b1, 5, n);
        wt(sup_reset_oe_out, 1'b0, 120, n);
        kick_en = 1'b0;
        cyc(7000);
        chk(wdog_expired_out, 1'b1);
        wt(wdog_expired_out, 1'b0, 1500, n);
        wt(sup_reset_oe_out, 1'b1, 3, n);
        wt(sup_reset_oe_out, 1'b0, 2000, n);
        chk(n > 1200 && n < 1350, 1'b1);
        wt(sup_reset_oe_out, 1'b1, 8500, n);
        chk(n > 7000 && wdog_expired_out === 1'b0, 1'b1);
        kick_en = 1'b1;
        wt(wdog_expired_out, 1'b1, 3000, n);
        wdog_float_in = 1'b1;
        kick_en = 1'b0;
        cyc(8000);
        chk(wdog_expired_out, 1'b1);
        chk(sup_reset_oe_out, 1'b0);
        conclude();
    end
endmodule : tb
`default_nettype wire
